// >>> design/usb_dev_irq_top.sv
// Top of the two-port device interrupt enable block with its register port.
`timescale 1ns/1ps
`include "usb_dev_irq_cfg.svh"
module usb_dev_irq_top
  import usb_dev_irq_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic [15:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  input wire logic i_vbus_valid,
  input wire logic i_otg_id,
  input wire logic [1:0] i_sof_eop,
  input wire logic [1:0] i_bus_reset,
  input wire logic [15:0] i_ep_ack,
  input wire logic [15:0] i_ep_stall,
  input wire logic [15:0] i_ep_timeout,
  input wire logic [15:0] i_ep_in_exc,
  input wire logic [15:0] i_ep_out_exc,
  input wire logic [15:0] i_ep_nak,
  output logic o_irq1,
  output logic o_irq2
);
  word_t rdata_reg, rdata_next, nak_en_reg;
  word_t en1, en2, sts1, sts2, frm1, frm2, cnt1, cnt2;
  logic vbus_s1_reg, vbus_s2_reg, id_s1_reg, id_s2_reg;

  // Address decode for the two ports and the shared NAK enable word.
  wire logic hit_en1 = (i_addr == `OFS_P1_IRQ_EN);
  wire logic hit_en2 = (i_addr == `OFS_P2_IRQ_EN);
  wire logic hit_st1 = (i_addr == `OFS_P1_STATUS);
  wire logic hit_st2 = (i_addr == `OFS_P2_STATUS);
  wire logic hit_fr1 = (i_addr == `OFS_P1_FRAME);
  wire logic hit_fr2 = (i_addr == `OFS_P2_FRAME);
  wire logic hit_ct1 = (i_addr == `OFS_P1_SOF_CNT);
  wire logic hit_ct2 = (i_addr == `OFS_P2_SOF_CNT);
  wire logic hit_nak = (i_addr == `OFS_NAK_EN);

  // Read mux; unmapped addresses read as zero.
  assign rdata_next = !i_rd ? `RST_ZERO :
    hit_en1 ? en1 : hit_en2 ? en2 : hit_st1 ? sts1 : hit_st2 ? sts2 :
    hit_fr1 ? frm1 : hit_fr2 ? frm2 : hit_ct1 ? cnt1 : hit_ct2 ? cnt2 :
    hit_nak ? nak_en_reg : `RST_ZERO;

  // VBUS and ID pins are double-synchronised; read data stands only in the cycle after the strobe.
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rdata_reg <= `RST_ZERO;
      nak_en_reg <= `RST_ZERO;
      vbus_s1_reg <= 1'b0;
      vbus_s2_reg <= 1'b0;
      id_s1_reg <= 1'b0;
      id_s2_reg <= 1'b0;
    end
    else
    begin
      rdata_reg <= rdata_next;
      if (i_wr && hit_nak)
        nak_en_reg <= i_wdata;
      vbus_s1_reg <= i_vbus_valid;
      vbus_s2_reg <= vbus_s1_reg;
      id_s1_reg <= i_otg_id;
      id_s2_reg <= id_s1_reg;
    end
  end
  assign o_rdata = rdata_reg;

  // Port one carries VBUS and ID enables; bits 15, 14, 11, 9, 8 and 7..0 gate events.
  usb_dev_port_irq #(.EN_MASK(`P1_EN_MASK)) u_port1 (
    .i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
    .i_vbus_sync(vbus_s2_reg), .i_id_sync(id_s2_reg),
    .i_sof_eop(i_sof_eop[0]), .i_bus_reset(i_bus_reset[0]),
    .i_ep_ack(i_ep_ack[7:0]), .i_ep_stall(i_ep_stall[7:0]),
    .i_ep_timeout(i_ep_timeout[7:0]), .i_ep_in_exc(i_ep_in_exc[7:0]),
    .i_ep_out_exc(i_ep_out_exc[7:0]), .i_ep_nak(i_ep_nak[7:0]),
    .i_nak_en(nak_en_reg[7:0]),
    .i_en_wr(i_wr && hit_en1), .i_sts_wr(i_wr && hit_st1), .i_cnt_wr(i_wr && hit_ct1),
    .i_wdata(i_wdata),
    .o_enable(en1), .o_status(sts1), .o_frame(frm1), .o_sof_cnt(cnt1), .o_irq(o_irq1)
  );

  // Port two has no OTG pins, so its VBUS and ID positions stay reserved.
  usb_dev_port_irq #(.EN_MASK(`P2_EN_MASK)) u_port2 (
    .i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
    .i_vbus_sync(1'b0), .i_id_sync(1'b0),
    .i_sof_eop(i_sof_eop[1]), .i_bus_reset(i_bus_reset[1]),
    .i_ep_ack(i_ep_ack[15:8]), .i_ep_stall(i_ep_stall[15:8]),
    .i_ep_timeout(i_ep_timeout[15:8]), .i_ep_in_exc(i_ep_in_exc[15:8]),
    .i_ep_out_exc(i_ep_out_exc[15:8]), .i_ep_nak(i_ep_nak[15:8]),
    .i_nak_en(nak_en_reg[15:8]),
    .i_en_wr(i_wr && hit_en2), .i_sts_wr(i_wr && hit_st2), .i_cnt_wr(i_wr && hit_ct2),
    .i_wdata(i_wdata),
    .o_enable(en2), .o_status(sts2), .o_frame(frm2), .o_sof_cnt(cnt2), .o_irq(o_irq2)
  );

  a_p2_reserved: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    en2[15:14] == 2'b00) else $error("port two OTG enables set");
  a_en_write: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (i_wr && hit_en1) |=> en1 == ($past(i_wdata) & (`P1_EN_MASK | `EP_MASK)))
    else $error("enable write lost");
  a_rst_flag: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    i_bus_reset[0] |=> sts1[`BIT_RST]) else $error("reset flag missed");
  a_ep_irq: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (i_ep_ack[0] && en1[0]) |=> o_irq1) else $error("ep irq missed");
  a_vbus_edge: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    $changed(vbus_s2_reg) |=> sts1[15]) else $error("vbus edge missed");
  // Endpoint three is the one the bench drives with NAK answers.
  a_nak_gate: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (i_ep_nak[3] && nak_en_reg[3]) |=> sts1[3]) else $error("nak event missed");
  a_clear_w1c: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (i_wr && hit_st1 && i_wdata[8] && !i_bus_reset[0]) |=> !sts1[8]) else $error("clear failed");
  a_read_data: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (i_rd && hit_en1) |=> o_rdata == $past(en1)) else $error("read data wrong");
  c_irq1: cover property (@(posedge i_ref_clk) disable iff (!i_nrst) $rose(o_irq1));
  c_irq2: cover property (@(posedge i_ref_clk) disable iff (!i_nrst) $rose(o_irq2));
  c_timeout: cover property (@(posedge i_ref_clk) disable iff (!i_nrst) sts1[11]);
endmodule

// >>> design/usb_dev_irq_cfg.svh
// Register map, field positions and reset values for the device interrupt enable block.
`ifndef USB_DEV_IRQ_CFG_SVH
`define USB_DEV_IRQ_CFG_SVH
`define ADDR_W 16
`define DATA_W 16
`define EP_CNT 8
`define OFS_P1_IRQ_EN 16'hC08C
`define OFS_P2_IRQ_EN 16'hC0AC
`define OFS_P1_STATUS 16'hC090
`define OFS_P2_STATUS 16'hC0B0
`define OFS_P1_FRAME 16'hC092
`define OFS_P2_FRAME 16'hC0B2
`define OFS_P1_SOF_CNT 16'hC094
`define OFS_P2_SOF_CNT 16'hC0B4
`define OFS_NAK_EN 16'hC0F0
`define BIT_VBUS 15
`define BIT_ID 14
`define BIT_TMO 11
`define BIT_SOF 9
`define BIT_RST 8
`define P1_EN_MASK 16'hCB00
`define P2_EN_MASK 16'h0B00
`define P1_STS_MASK 16'hCB00
`define P2_STS_MASK 16'h0B00
`define EP_MASK 16'h00FF
`define RST_ZERO 16'h0000
`define SOF_CNT_RST 16'h2EE0
`define ONE_16 16'h0001
`endif

// >>> design/usb_dev_irq_pkg.sv
// Types shared by the device interrupt enable block.
package usb_dev_irq_pkg;
  typedef logic [15:0] word_t;
  typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_RUN = 1'b1} tmo_state_t;
endpackage

// >>> design/usb_dev_port_irq.sv
// One device port: sticky status flags, SOF/EOP timeout counter and frame counter.
`timescale 1ns/1ps
`include "usb_dev_irq_cfg.svh"
module usb_dev_port_irq
  import usb_dev_irq_pkg::*;
#(
  parameter word_t EN_MASK = `P1_EN_MASK
)
(
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_vbus_sync,
  input wire logic i_id_sync,
  input wire logic i_sof_eop,
  input wire logic i_bus_reset,
  input wire logic [7:0] i_ep_ack,
  input wire logic [7:0] i_ep_stall,
  input wire logic [7:0] i_ep_timeout,
  input wire logic [7:0] i_ep_in_exc,
  input wire logic [7:0] i_ep_out_exc,
  input wire logic [7:0] i_ep_nak,
  input wire logic [7:0] i_nak_en,
  input wire logic i_en_wr,
  input wire logic i_sts_wr,
  input wire logic i_cnt_wr,
  input wire logic [15:0] i_wdata,
  output logic [15:0] o_enable,
  output logic [15:0] o_status,
  output logic [15:0] o_frame,
  output logic [15:0] o_sof_cnt,
  output logic o_irq
);
  word_t en_reg, en_next, sts_reg, sts_next, ev, frame_reg, frame_next;
  word_t cnt_reg, cnt_next, tmr_reg, tmr_next;
  logic vbus_d_reg, id_d_reg, tmo_ev, irq_reg;
  tmo_state_t st_reg, st_next;
  wire logic [7:0] ep_done;

  // Both edges of the OTG levels count; the reserved mask drops them on port two.
  wire logic vbus_edge = vbus_d_reg ^ i_vbus_sync;
  wire logic id_edge = id_d_reg ^ i_id_sync;
  // Transaction done: ACK, STALL, timeout, exceptions, and NAK when enabled.
  assign ep_done = i_ep_ack | i_ep_stall | i_ep_timeout | i_ep_in_exc | i_ep_out_exc
    | (i_ep_nak & i_nak_en);
  // Timeout is armed by the first SOF/EOP so an idle bus after reset stays quiet.
  assign tmo_ev = (st_reg == ST_RUN) && !i_sof_eop && (tmr_reg == cnt_reg);
  always_comb
  begin
    ev = `RST_ZERO;
    ev[`BIT_VBUS] = vbus_edge;
    ev[`BIT_ID] = id_edge;
    ev[`BIT_TMO] = tmo_ev;
    ev[`BIT_SOF] = i_sof_eop;
    ev[`BIT_RST] = i_bus_reset;
    ev[7:0] = ep_done;
  end
  // Reserved enable bits are forced to zero whatever software writes.
  assign en_next = i_en_wr ? (i_wdata & (EN_MASK | `EP_MASK)) : en_reg;
  // Write one clears; a new event in the same cycle wins over the clear.
  assign sts_next = ((sts_reg & ~(i_sts_wr ? i_wdata : `RST_ZERO)) | ev)
    & (EN_MASK | `EP_MASK);
  // Frame counts timeouts since the last SOF/EOP, restarting on each marker.
  assign frame_next = i_sof_eop ? `RST_ZERO : (tmo_ev ? frame_reg + `ONE_16 : frame_reg);
  assign cnt_next = i_cnt_wr ? i_wdata : cnt_reg;
  assign tmr_next = (i_sof_eop || tmo_ev) ? `RST_ZERO : tmr_reg + `ONE_16;
  assign st_next = i_sof_eop ? ST_RUN : st_reg;

  // Status and enable state; all enables clear on reset.
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      en_reg <= `RST_ZERO;
      sts_reg <= `RST_ZERO;
      frame_reg <= `RST_ZERO;
      cnt_reg <= `SOF_CNT_RST;
      tmr_reg <= `RST_ZERO;
      st_reg <= ST_IDLE;
      vbus_d_reg <= 1'b0;
      id_d_reg <= 1'b0;
      irq_reg <= 1'b0;
    end
    else
    begin
      en_reg <= en_next;
      sts_reg <= sts_next;
      frame_reg <= frame_next;
      cnt_reg <= cnt_next;
      tmr_reg <= tmr_next;
      st_reg <= st_next;
      vbus_d_reg <= i_vbus_sync;
      id_d_reg <= i_id_sync;
      irq_reg <= |(sts_next & en_next);
    end
  end
  assign o_enable = en_reg;
  assign o_status = sts_reg;
  assign o_frame = frame_reg;
  assign o_sof_cnt = cnt_reg;
  assign o_irq = irq_reg;

  a_irq_follows: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (|(sts_reg & en_reg)) == irq_reg) else $error("irq not matching flags");
  a_sof_flag_set: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    i_sof_eop |=> sts_reg[`BIT_SOF]) else $error("sof flag missed");
endmodule

// >>> sim/usb_host_model.sv
// Host side of the USB link: one-cycle bus and endpoint event pulses.
`timescale 1ns/1ps
module usb_host_model
(
  input wire logic i_ref_clk,
  output logic [1:0] o_sof_eop,
  output logic [1:0] o_bus_reset,
  output logic [5:0][15:0] o_ev
);
  // The link is quiet until the bench asks for a marker or a handshake.
  initial
  begin
    o_sof_eop = 2'h0;
    o_bus_reset = 2'h0;
    o_ev = '0;
  end

  // Kinds 0 to 5 are ACK, STALL, timeout, IN and OUT exception, NAK; 6 is SOF/EOP, 7 bus reset.
  task automatic pulse(input int kind, input int bit_no);
    @(posedge i_ref_clk);
    if (kind == 6)
      o_sof_eop[bit_no] <= 1'b1;
    else if (kind == 7)
      o_bus_reset[bit_no] <= 1'b1;
    else
      o_ev[kind][bit_no] <= 1'b1;
    @(posedge i_ref_clk);
    o_sof_eop <= 2'h0;
    o_bus_reset <= 2'h0;
    o_ev <= '0;
  endtask
endmodule

// >>> sim/tb_usb_device_interrupt_enable.sv
// Self-checking bench for the two-port device interrupt enable block.
`timescale 1ns/1ps
`include "usb_dev_irq_cfg.svh"
module tb_usb_device_interrupt_enable;
  import usb_dev_irq_pkg::*;
  logic i_ref_clk, i_nrst, i_wr, i_rd, i_vbus_valid, i_otg_id, o_irq1, o_irq2;
  logic [15:0] i_addr, i_wdata, o_rdata;
  logic [1:0] sof_eop, bus_reset;
  logic [5:0][15:0] ev;
  word_t rd_val;
  int n_errors = 0;
  int checks_done = 0;

  usb_dev_irq_top uut (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_vbus_valid(i_vbus_valid), .i_otg_id(i_otg_id), .i_sof_eop(sof_eop),
    .i_bus_reset(bus_reset), .i_ep_ack(ev[0]), .i_ep_stall(ev[1]), .i_ep_timeout(ev[2]),
    .i_ep_in_exc(ev[3]), .i_ep_out_exc(ev[4]), .i_ep_nak(ev[5]), .o_irq1(o_irq1),
    .o_irq2(o_irq2));
  usb_host_model host (.i_ref_clk(i_ref_clk), .o_sof_eop(sof_eop), .o_bus_reset(bus_reset),
    .o_ev(ev));

  // Reference clock at 200 MHz.
  initial
  begin
    i_ref_clk = 1'b0;
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end

  task automatic check(input word_t seen, input word_t exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic reg_wr(input word_t a, input word_t d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask

  // Read data stand for one cycle only, so they are taken at the falling edge inside it.
  task automatic rd_chk(input word_t a, input word_t exp);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    @(negedge i_ref_clk);
    check(o_rdata, exp);
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // The tests need a few hundred cycles; this limit is reached only by a hang.
  initial
  begin
    #100000;
    n_errors++;
    print_verdict();
  end

  initial
  begin
    i_nrst = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 16'h0000;
    i_wdata = 16'h0000;
    i_vbus_valid = 1'b0;
    i_otg_id = 1'b0;
    repeat (4) @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    rd_chk(`OFS_P1_IRQ_EN, 16'h0000);
    rd_chk(`OFS_P2_IRQ_EN, 16'h0000);
    reg_wr(`OFS_P1_IRQ_EN, 16'hCBFF);
    reg_wr(`OFS_P2_IRQ_EN, 16'h0BFF);
    rd_chk(`OFS_P1_IRQ_EN, 16'hCBFF);
    rd_chk(`OFS_P2_IRQ_EN, 16'h0BFF);
    rd_chk(16'hC0FE, 16'h0000);
    // Each endpoint event kind except NAK on both ports, then cleared by writing ones.
    for (int k = 0; k < 5; k++)
    begin
      host.pulse(k, k);
      host.pulse(k, k + 9);
      rd_chk(`OFS_P1_STATUS, 16'h0001 << k);
      rd_chk(`OFS_P2_STATUS, 16'h0002 << k);
      check({15'h0, o_irq1 & o_irq2}, 16'h0001);
      reg_wr(`OFS_P1_STATUS, 16'h0001 << k);
      reg_wr(`OFS_P2_STATUS, 16'h0002 << k);
      rd_chk(`OFS_P1_STATUS, 16'h0000);
      check({14'h0, o_irq1, o_irq2}, 16'h0000);
    end
    host.pulse(5, 3);
    rd_chk(`OFS_P1_STATUS, 16'h0000);
    reg_wr(`OFS_NAK_EN, 16'h0808);
    host.pulse(5, 3);
    host.pulse(5, 11);
    host.pulse(6, 0);
    host.pulse(7, 1);
    host.pulse(7, 0);
    rd_chk(`OFS_P1_STATUS, 16'h0308);
    rd_chk(`OFS_P2_STATUS, 16'h0108);
    reg_wr(`OFS_P1_IRQ_EN, 16'h0000);
    rd_chk(`OFS_P1_STATUS, 16'h0308);
    check({15'h0, o_irq1}, 16'h0000);
    reg_wr(`OFS_P1_IRQ_EN, 16'h0200);
    reg_wr(`OFS_P1_STATUS, 16'h0008);
    rd_chk(`OFS_P1_STATUS, 16'h0300);
    check({15'h0, o_irq1}, 16'h0001);
    reg_wr(`OFS_P1_IRQ_EN, 16'h0008);
    // The interrupt register updates on the write edge, so look half a cycle later.
    @(negedge i_ref_clk);
    check({15'h0, o_irq1}, 16'h0000);
    reg_wr(`OFS_P1_STATUS, 16'hCBFF);
    reg_wr(`OFS_P2_STATUS, 16'h0BFF);
    // Both edges of both OTG pins; port two keeps those bits reserved.
    for (int e = 0; e < 4; e++)
    begin
      if (e % 2 == 1)
        i_otg_id <= ~i_otg_id;
      else
        i_vbus_valid <= ~i_vbus_valid;
      repeat (6) @(posedge i_ref_clk);
      rd_chk(`OFS_P1_STATUS, (e % 2 == 1) ? 16'h4000 : 16'h8000);
      rd_chk(`OFS_P2_STATUS, 16'h0000);
      reg_wr(`OFS_P1_STATUS, 16'hC000);
    end
    // A short marker period so one timeout lands between two markers.
    reg_wr(`OFS_P1_SOF_CNT, 16'h0014);
    host.pulse(6, 0);
    repeat (30) @(posedge i_ref_clk);
    rd_chk(`OFS_P1_STATUS, 16'h0A00);
    rd_chk(`OFS_P1_FRAME, 16'h0001);
    host.pulse(6, 0);
    rd_chk(`OFS_P1_FRAME, 16'h0000);
    @(posedge i_ref_clk);
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    rd_chk(`OFS_P2_IRQ_EN, 16'h0000);
    rd_chk(`OFS_P2_SOF_CNT, `SOF_CNT_RST);
    print_verdict();
  end
endmodule
